// ### design/liu_chan_defines.vh
// Constants for the per-channel control and interrupt-enable register bank
// What this block does
// - Transmit power bit D3 turns channel transmitter on or off when global pin high.
// - Global transmit-enable pin low forces all eight transmitters off.
// - Transmit power bits reset to zero, transmitters start powered off.
// - Loopback field: top bit 0 none; 100 dual, 101 analog, 110 remote, 111 digital.
// - Bit D5 selects HDB3 when 0, AMI when 1, single-rail only.
// - Resistor field: 00 none, 01 240 ohm, 10 210 ohm, 11 150 ohm.
// - Rising D2 seen on transmit clock inserts one bipolar violation.
// - Rising D1 seen on transmit clock inserts one bit error.
// - Enables D6, D5, D4 unmask driver-fail, FIFO-limit, line-violation sources.
// - Enables D2, D1, D0 unmask all-ones, signal-loss, pattern-detect sources.
// - Interrupt asserts only when source enable and global enable are both 1.
// - Eight channel copies, channel n at channel-0 offset plus n times 0x10.
// - Reserved bits have no effect on the channel.
// - Status flags track their condition regardless of interrupt enables.
// - FIFO-limit flag set when FIFO pointers lie within three bits.
`ifndef LIU_CHAN_DEFINES_VH
`define LIU_CHAN_DEFINES_VH
`define OFS_TX_POWER_LOOPBACK 4'h2
`define OFS_CODING_RESISTOR 4'h3
`define OFS_CHANNEL_IRQ_EN 4'h4
`define OFS_CHANNEL_STATUS 4'h5
`define RST_TX_POWER_LOOPBACK 8'h00
`define RST_CODING_RESISTOR 8'h00
`define RST_CHANNEL_IRQ_EN 8'h00
`define MASK_TX_POWER_LOOPBACK 8'h0f
`define MASK_CODING_RESISTOR 8'h3e
`define MASK_CHANNEL_IRQ_EN 8'h77
`define BIT_TX_POWER_ON 3
`define BIT_LINE_CODE_SELECT 5
`define BIT_INJECT_BPV 2
`define BIT_INJECT_BIT_ERROR 1
`define LOOP_DUAL 3'h4
`define LOOP_ANALOG 3'h5
`define LOOP_REMOTE 3'h6
`define LOOP_DIGITAL 3'h7
`define FIFO_LIMIT_DISTANCE 3
`endif

// ### design/liu_channel_ctrl_irq_regs.v
// Per-channel control, error insertion and interrupt-enable register bank
`timescale 1ns/100ps
`include "liu_chan_defines.vh"
module liu_channel_ctrl_irq_regs #(
   parameter CHANNELS = 8,
   parameter PTR_WIDTH = 6
) (
   input wire clk,
   input wire reset,
   input wire [7:0] regAddr,
   input wire [7:0] regWrData,
   input wire regWrite,
   input wire regRead,
   output reg [7:0] regRdData,
   input wire globalTxEnablePin,
   input wire globalIrqEn,
   input wire [CHANNELS-1:0] txLineClock,
   input wire [CHANNELS-1:0] driverFailCond,
   input wire [CHANNELS-1:0] lineViolationCond,
   input wire [CHANNELS-1:0] allOnesCond,
   input wire [CHANNELS-1:0] rxSignalLossCond,
   input wire [CHANNELS-1:0] patternDetectCond,
   input wire [CHANNELS*PTR_WIDTH-1:0] fifoRdPtr,
   input wire [CHANNELS*PTR_WIDTH-1:0] fifoWrPtr,
   output wire [CHANNELS-1:0] txPowerOn,
   output wire [CHANNELS*3-1:0] loopbackMode,
   output wire [CHANNELS-1:0] dualLoopback,
   output wire [CHANNELS-1:0] analogLoopback,
   output wire [CHANNELS-1:0] remoteLoopback,
   output wire [CHANNELS-1:0] digitalLoopback,
   output wire [CHANNELS-1:0] lineCodeSelect,
   output wire [CHANNELS*2-1:0] rxExtResistorSel,
   output reg [CHANNELS-1:0] injectBipolarViolation,
   output reg [CHANNELS-1:0] injectBitError,
   output reg irqOut
);

   // Per-channel register copies
   reg [7:0] txCtrl_q [0:CHANNELS-1];
   reg [7:0] codeCtrl_q [0:CHANNELS-1];
   reg [7:0] irqEn_q [0:CHANNELS-1];
   reg [7:0] status_q [0:CHANNELS-1];
   // Transmit clock and insertion history
   reg [CHANNELS-1:0] tclkPrev_q;
   reg [CHANNELS-1:0] bpvPrev_q;
   reg [CHANNELS-1:0] berPrev_q;
   // Combinational next values
   reg [7:0] rdData_d;
   reg irq_d;
   // Address fields
   wire [3:0] chanSel;
   wire [3:0] regSel;
   // Loop indices, one per process
   integer i;
   integer j;
   integer k;
   integer m;
   integer txIdx;
   integer codeIdx;
   integer irqIdx;

   // Pointer distance within the limit, either direction
   function fifoNear;
      input [PTR_WIDTH-1:0] rd;
      input [PTR_WIDTH-1:0] wr;
      reg [PTR_WIDTH-1:0] diffUp;
      reg [PTR_WIDTH-1:0] diffDown;
      begin
         // Kept at pointer width so the distance wraps like the FIFO
         diffUp = wr - rd;
         diffDown = rd - wr;
         fifoNear = (diffUp <= `FIFO_LIMIT_DISTANCE) || (diffDown <= `FIFO_LIMIT_DISTANCE);
      end
   endfunction

   // Write strobe hits one register of one channel
   function regHit;
      input [3:0] chan;
      input [3:0] ofs;
      input integer idx;
      input [3:0] want;
      begin
         regHit = (chan == idx) && (ofs == want);
      end
   endfunction

   // Loopback field equals one active mode
   function loopIs;
      input [2:0] field;
      input [2:0] mode;
      begin
         loopIs = (field == mode);
      end
   endfunction

   // Channel in upper nibble, register in lower
   assign chanSel = regAddr[7:4];
   assign regSel = regAddr[3:0];

   // Transmit power and loopback register, reserved bits held at zero
   always @(posedge clk) begin
      for (txIdx = 0; txIdx < CHANNELS; txIdx = txIdx + 1) begin
         if (reset)
            txCtrl_q[txIdx] <= `RST_TX_POWER_LOOPBACK;
         else if (regWrite && regHit(chanSel, regSel, txIdx, `OFS_TX_POWER_LOOPBACK))
            txCtrl_q[txIdx] <= regWrData & `MASK_TX_POWER_LOOPBACK;
      end
   end

   // Coding, resistor and insertion register, reserved bits held at zero
   always @(posedge clk) begin
      for (codeIdx = 0; codeIdx < CHANNELS; codeIdx = codeIdx + 1) begin
         if (reset)
            codeCtrl_q[codeIdx] <= `RST_CODING_RESISTOR;
         else if (regWrite && regHit(chanSel, regSel, codeIdx, `OFS_CODING_RESISTOR))
            codeCtrl_q[codeIdx] <= regWrData & `MASK_CODING_RESISTOR;
      end
   end

   // Interrupt enable register, reserved bits held at zero
   always @(posedge clk) begin
      for (irqIdx = 0; irqIdx < CHANNELS; irqIdx = irqIdx + 1) begin
         if (reset)
            irqEn_q[irqIdx] <= `RST_CHANNEL_IRQ_EN;
         else if (regWrite && regHit(chanSel, regSel, irqIdx, `OFS_CHANNEL_IRQ_EN))
            irqEn_q[irqIdx] <= regWrData & `MASK_CHANNEL_IRQ_EN;
      end
   end

   // Live status flags, independent of enables
   always @(posedge clk) begin
      for (k = 0; k < CHANNELS; k = k + 1) begin
         // Reserved positions D7 and D3 read zero
         if (reset)
            status_q[k] <= 8'h00;
         else
            status_q[k] <= {1'b0, driverFailCond[k],
               fifoNear(fifoRdPtr[k*PTR_WIDTH +: PTR_WIDTH], fifoWrPtr[k*PTR_WIDTH +: PTR_WIDTH]),
               lineViolationCond[k], 1'b0, allOnesCond[k], rxSignalLossCond[k],
               patternDetectCond[k]};
      end
   end

   // Insertion bits sampled on transmit clock rising edge
   always @(posedge clk) begin
      if (reset) begin
         tclkPrev_q <= {CHANNELS{1'b0}};
         bpvPrev_q <= {CHANNELS{1'b0}};
         berPrev_q <= {CHANNELS{1'b0}};
         injectBipolarViolation <= {CHANNELS{1'b0}};
         injectBitError <= {CHANNELS{1'b0}};
      end else begin
         tclkPrev_q <= txLineClock;
         // Pulses default low, raised only on a clean rising bit
         for (m = 0; m < CHANNELS; m = m + 1) begin
            injectBipolarViolation[m] <= 1'b0;
            injectBitError[m] <= 1'b0;
            if (txLineClock[m] && !tclkPrev_q[m]) begin
               bpvPrev_q[m] <= codeCtrl_q[m][`BIT_INJECT_BPV];
               berPrev_q[m] <= codeCtrl_q[m][`BIT_INJECT_BIT_ERROR];
               injectBipolarViolation[m] <= codeCtrl_q[m][`BIT_INJECT_BPV] & ~bpvPrev_q[m];
               injectBitError[m] <= codeCtrl_q[m][`BIT_INJECT_BIT_ERROR] & ~berPrev_q[m];
            end
         end
      end
   end

   // Control outputs per channel
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g = g + 1) begin : chanOut
         assign txPowerOn[g] = globalTxEnablePin & txCtrl_q[g][`BIT_TX_POWER_ON];
         assign loopbackMode[g*3 +: 3] = txCtrl_q[g][2:0];
         // Loopback decodes, one hot per mode
         assign dualLoopback[g] = loopIs(txCtrl_q[g][2:0], `LOOP_DUAL);
         assign analogLoopback[g] = loopIs(txCtrl_q[g][2:0], `LOOP_ANALOG);
         assign remoteLoopback[g] = loopIs(txCtrl_q[g][2:0], `LOOP_REMOTE);
         assign digitalLoopback[g] = loopIs(txCtrl_q[g][2:0], `LOOP_DIGITAL);
         assign lineCodeSelect[g] = codeCtrl_q[g][`BIT_LINE_CODE_SELECT];
         assign rxExtResistorSel[g*2 +: 2] = codeCtrl_q[g][4:3];
      end
   endgenerate

   // Interrupt combine across channels and sources
   always @* begin
      irq_d = 1'b0;
      for (j = 0; j < CHANNELS; j = j + 1)
         irq_d = irq_d | (|(status_q[j] & irqEn_q[j]));
   end

   // Read mux, unmapped channels and offsets read zero
   always @* begin
      rdData_d = 8'h00;
      for (i = 0; i < CHANNELS; i = i + 1) begin
         if (chanSel == i) begin
            case (regSel)
               `OFS_TX_POWER_LOOPBACK: rdData_d = txCtrl_q[i];
               `OFS_CODING_RESISTOR: rdData_d = codeCtrl_q[i];
               `OFS_CHANNEL_IRQ_EN: rdData_d = irqEn_q[i];
               `OFS_CHANNEL_STATUS: rdData_d = status_q[i];
               default: rdData_d = 8'h00;
            endcase
         end
      end
   end

   // Read data register, holds until the next read
   always @(posedge clk) begin
      if (reset)
         regRdData <= 8'h00;
      else if (regRead)
         regRdData <= rdData_d;
   end

   // Interrupt register, global enable gates every source
   always @(posedge clk) begin
      if (reset)
         irqOut <= 1'b0;
      else
         irqOut <= globalIrqEn & irq_d;
   end

endmodule

// ### bench/liu_channel_ctrl_irq_regs_checker.sv
// Port assertions for the channel control bank
`timescale 1ns/100ps
module liu_channel_ctrl_irq_regs_checker #(parameter CHANNELS = 8) (
   input wire clk,
   input wire reset,
   input wire regWrite,
   input wire regRead,
   input wire [7:0] regRdData,
   input wire globalTxEnablePin,
   input wire globalIrqEn,
   input wire [CHANNELS-1:0] txPowerOn,
   input wire [CHANNELS-1:0] injectBipolarViolation,
   input wire [CHANNELS-1:0] injectBitError,
   input wire irqOut
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_irqOff; !globalIrqEn [*3]; endsequence
   property p_off; !globalTxEnablePin |-> txPowerOn == 0; endproperty
   a_off: assert property (p_off) else $error("tx on");
   property p_rst; disable iff (1'b0) reset |=> !txPowerOn && !irqOut && !regRdData; endproperty
   a_rst: assert property (p_rst) else $error("reset");
   property p_tx; !$past(regWrite) && $stable(globalTxEnablePin) |-> $stable(txPowerOn); endproperty
   a_tx: assert property (p_tx) else $error("tx moved");
   property p_bpv; (injectBipolarViolation & $past(injectBipolarViolation)) == 0; endproperty
   a_bpv: assert property (p_bpv) else $error("bpv long");
   property p_ber; (injectBitError & $past(injectBitError)) == 0; endproperty
   a_ber: assert property (p_ber) else $error("ber long");
   property p_gate; s_irqOff |-> !irqOut; endproperty
   a_gate: assert property (p_gate) else $error("irq");
   property p_rise; $rose(irqOut) |-> $past(globalIrqEn) || $past(globalIrqEn, 2); endproperty
   a_rise: assert property (p_rise) else $error("irq rise");
   property p_hold; !$past(regRead) |-> $stable(regRdData); endproperty
   a_hold: assert property (p_hold) else $error("rd moved");
endmodule
bind liu_channel_ctrl_irq_regs liu_channel_ctrl_irq_regs_checker #(.CHANNELS(CHANNELS)) i_chk (.*);

// ### bench/tb_liu_channel_ctrl_irq_regs.sv
// Testbench for the channel control bank
`timescale 1ns/100ps
module tb_liu_channel_ctrl_irq_regs;
   logic clk, reset, regWrite, regRead, globalTxEnablePin, globalIrqEn, irqOut;
   logic [7:0] regAddr, regWrData, regRdData, txLineClock, txPowerOn, lineCodeSelect, injectBitError;
   logic [7:0] dualLoopback, analogLoopback, remoteLoopback, digitalLoopback, injectBipolarViolation;
   logic [6:0] sv;
   logic [15:0] rxExtResistorSel;
   logic [23:0] loopbackMode;
   logic [7:0] ms [3] = '{8'h0f, 8'h3e, 8'h77};
   int mismatches, checks, nb;
   // Channel 3 sources
   wire [7:0] driverFailCond = 8'(sv[6]) << 3, lineViolationCond = 8'(sv[4]) << 3;
   wire [7:0] allOnesCond = 8'(sv[2]) << 3, rxSignalLossCond = 8'(sv[1]) << 3, patternDetectCond = 8'(sv[0]) << 3;
   wire [47:0] fifoRdPtr = '0, fifoWrPtr = {{4{6'h20}}, sv[5] ? 6'h03 : 6'h20, {3{6'h20}}};
   liu_channel_ctrl_irq_regs i_dut (.*);
   task w(input int n);
      repeat (n) @(negedge clk);
   endtask
   task chk(input logic [7:0] g, e);
      checks++;
      if (g !== e) mismatches++;
      if (g !== e) $display("ERROR %0t got %h exp %h", $time, g, e);
   endtask
   // Register access
   task wr(input logic [7:0] a, d);
      w(1);
      {regAddr, regWrData, regWrite} = {a, d, 1'b1};
      w(1);
      regWrite = 0;
   endtask
   task rd(input logic [7:0] a, e);
      w(1);
      {regAddr, regRead} = {a, 1'b1};
      w(1);
      regRead = 0;
      chk(regRdData, e);
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Clock
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   // Watchdog
   initial begin
      #100000;
      mismatches++;
      print_verdict;
   end
   // Main sequence
   initial begin
      {reset, regWrite, regRead, globalTxEnablePin, globalIrqEn, sv} = 12'h800;
      {regAddr, regWrData, txLineClock, mismatches, checks} = '0;
      w(10);
      reset = 0;
      for (int o = 2; o < 5; o++) rd(8'h70 + 8'(o), 8'h00);
      for (int i = 0; i < 24; i++) wr(8'(i / 3 * 16 + i % 3 + 2), 8'hf0 | 8'(i));
      for (int i = 0; i < 24; i++) rd(8'(i / 3 * 16 + i % 3 + 2), (8'hf0 | 8'(i)) & ms[i % 3]);
      wr(8'h86, 8'hff);
      rd(8'h86, 8'h00);
      globalTxEnablePin = 1;
      w(1);
      chk(txPowerOn, 8'h38);
      globalTxEnablePin = 0;
      w(1);
      chk(txPowerOn, 8'h00);
      for (int v = 0; v < 8; v++) begin
         wr(8'h02, 8'(v));
         wr(8'h23, 8'(v << 3));
         chk({digitalLoopback[0], remoteLoopback[0], analogLoopback[0], dualLoopback[0]}, 8'(16 >> (8 - v)));
         chk({lineCodeSelect[2], rxExtResistorSel[5:4]}, 8'(v));
         chk(8'(loopbackMode[2:0]), 8'(v));
      end
      wr(8'h13, 8'h00);
      wr(8'h13, 8'h06);
      for (int k = 3; k >= 0; k -= 3) begin
         nb = 0;
         txLineClock = 8'h00;
         w(2);
         txLineClock = 8'h02;
         repeat (6) begin
            w(1);
            nb += (injectBipolarViolation === 8'h02) + 2 * (injectBitError === 8'h02);
         end
         chk(8'(nb), 8'(k));
      end
      globalIrqEn = 1;
      for (int b = 0; b < 7; b++) begin
         if (b == 3) continue;
         sv = 7'(1 << b);
         wr(8'h34, 8'h00);
         w(3);
         chk(irqOut, 8'h00);
         rd(8'h35, 8'(sv));
         wr(8'h34, 8'(sv));
         w(3);
         chk(irqOut, 8'h01);
         globalIrqEn = 0;
         w(3);
         chk(irqOut, 8'h00);
         globalIrqEn = 1;
      end
      print_verdict;
   end
endmodule
